/* File: hpf_pkg.sv */
package hpf_pkg;
  // ----------------------------------------------------------------------
  // Port widths and fixed addresses
  // ----------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam logic [7:0] DIRECT_FIFO_ADDR = 8'hff;
  localparam logic [7:0] DMA_PORT_ADDR = 8'h80;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Wait counter load; wait is held at least one cycle more than this before data is presented
  localparam int WAIT_CYCLES = 2;
  localparam logic [1:0] WAIT_CNT = 2'(WAIT_CYCLES);

  // ----------------------------------------------------------------------
  // Device end states (one-hot)
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_WAIT = 5'h02,
    DS_DRIVE = 5'h04,
    DS_DMA = 5'h08,
    DS_DWORD = 5'h10
  } hpf_dev_state_t;

  // ----------------------------------------------------------------------
  // Processor end states (one-hot)
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    PS_IDLE = 7'h01,
    PS_SEL = 7'h02,
    PS_OE = 7'h04,
    PS_CAP = 7'h08,
    PS_DROP_OE = 7'h10,
    PS_DROP_CS = 7'h20,
    PS_DROP_ACK = 7'h40
  } hpf_proc_state_t;
endpackage : hpf_pkg

/* File: hpf_port_if.sv */
`timescale 1ns/1ns
// Parallel port between the processor and the controller; all strobes
// are active low and wait is driven only by the device.
interface hpf_port_if;
  import hpf_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic cs_n;
  logic oe_n;
  logic wait_n;
  logic dma_request_n;
  logic dma_grant_n;
  logic [DATA_W-1:0] data_out;
  logic data_oe;
  // Resolved bus level seen by the processor
  logic [DATA_W-1:0] data;
  assign data = data_oe ? data_out : '0;

  modport dev (
    input addr, cs_n, oe_n, dma_grant_n,
    output wait_n, dma_request_n, data_out, data_oe
  );
  modport proc (
    output addr, cs_n, oe_n, dma_grant_n,
    input wait_n, dma_request_n, data
  );
endinterface : hpf_port_if

/* File: hpf_dev.sv */
`timescale 1ns/1ns
// What this block does
// - Direct read returns one 32-bit word
// - Processor repeats full sequence per word
// - Wait and output strobe in any order
// - Device starts DMA by asserting request
// - One request covers the whole block
// - Request held until grant is seen
// - Processor ends block at zero count
// - Device keeps its own DMA word count
// - DMA uses fixed port address 0x80
// - Device is DMA slave only
// - Processor asserts grant, select, then strobe
// - Select and strobe low drive next word
// - Processor drops strobe, select, then grant
// - Further words reuse grant without request
// - Request release order versus select free
// - Wait never asserted during DMA
// - Address 0xFF select: wait, word, release
// - Processor direct read pin sequence

// Limitation: a block word is taken only while the fifo holds data.
// The processor end has no wait to stretch a DMA cycle, so the local
// fifo must stay ahead of the block for the whole transfer; a stall
// there costs a zero word read from the undriven bus rather than a wait state.
module hpf_dev #(
  parameter int CNT_WIDTH = hpf_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  hpf_port_if.dev port,
  // FIFO read side
  input wire logic [hpf_pkg::DATA_W-1:0] fifo_data,
  input wire logic fifo_valid,
  output logic fifo_pop,
  // Block start: number of words to send by DMA
  input wire logic dma_start,
  input wire logic [CNT_WIDTH-1:0] dma_words,
  output logic dma_busy,
  output logic [CNT_WIDTH-1:0] dma_done_cnt
);
  import hpf_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    // Sequencing
    hpf_dev_state_t st;
    logic [1:0] wcnt;
    // Pin drivers, all registered so the port never glitches
    logic wait_n;
    logic req_n;
    logic [DATA_W-1:0] dout;
    logic doe;
    // Local side
    logic pop;
    logic busy;
    // Block bookkeeping, apart from the processor's own count
    logic [CNT_WIDTH-1:0] left;
    logic [CNT_WIDTH-1:0] done;
  } hpf_dev_regs_t;

  hpf_dev_regs_t s_reg;
  hpf_dev_regs_t s_next;

  // ----------------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------------
  // Strobes are active low; decode them once so the states read plainly
  logic sel;
  logic rd;
  logic dma_hit;
  logic direct_hit;
  assign sel = !port.cs_n;
  assign rd = sel && !port.oe_n;
  // Block word: grant, both strobes and the fixed port address
  assign dma_hit = !port.dma_grant_n && rd &&
      port.addr == DMA_PORT_ADDR;
  // Direct reads are ignored while a grant is out, so a block word
  // is never mistaken for a direct fetch
  assign direct_hit = sel && port.dma_grant_n &&
      port.addr == DIRECT_FIFO_ADDR;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // One pass builds the whole next state from the current one
  always_comb begin
    s_next = s_reg;
    s_next.pop = 1'b0;
    case (s_reg.st)
      DS_IDLE: begin
        s_next.doe = 1'b0;
        // A block start wins over a direct select in the same cycle
        if (dma_start && dma_words != '0) begin
          s_next.req_n = 1'b0;
          s_next.busy = 1'b1;
          s_next.left = dma_words;
          s_next.done = '0;
          s_next.st = DS_DMA;
        end else if (direct_hit) begin
          // Wait goes low whether the strobe is already down or not
          s_next.wait_n = 1'b0;
          s_next.wcnt = WAIT_CNT;
          s_next.st = DS_WAIT;
        end
      end
      DS_WAIT: begin
        // Wait holds until a word exists and the wait count runs out;
        // the word is shown only once the strobe is down
        if (s_reg.wcnt != 2'h0) begin
          s_next.wcnt = s_reg.wcnt - 2'h1;
        end else if (fifo_valid && !port.oe_n) begin
          s_next.dout = fifo_data;
          s_next.doe = 1'b1;
          s_next.pop = 1'b1;
          s_next.wait_n = 1'b1;
          s_next.st = DS_DRIVE;
        end
      end
      DS_DRIVE: begin
        // One word per select; the next word needs a new select.
        // Data stays on the bus until select rises, whatever oe does.
        if (!sel) begin
          s_next.doe = 1'b0;
          s_next.st = DS_IDLE;
        end
      end
      DS_DMA: begin
        // Request is released on grant, whatever select is doing;
        // the processor may already be selecting, which is allowed
        if (!port.dma_grant_n) begin
          s_next.req_n = 1'b1;
        end
        // The word counter moves with the pop so both stay in step
        if (dma_hit && fifo_valid) begin
          s_next.dout = fifo_data;
          s_next.doe = 1'b1;
          s_next.pop = 1'b1;
          s_next.done = s_reg.done + CNT_WIDTH'(1);
          s_next.left = s_reg.left - CNT_WIDTH'(1);
          s_next.st = DS_DWORD;
        end
      end
      DS_DWORD: begin
        // Bus released as soon as the strobe rises
        if (port.oe_n) begin
          s_next.doe = 1'b0;
        end
        // Cycle ends when grant goes away; no new request in a block
        if (port.dma_grant_n) begin
          s_next.doe = 1'b0;
          if (s_reg.left == '0) begin
            // Last word: drop busy and let direct reads back in
            s_next.busy = 1'b0;
            s_next.st = DS_IDLE;
          end else begin
            s_next.st = DS_DMA;
          end
        end
      end
      default: begin
        s_next.st = DS_IDLE;
      end
    endcase
    // Wait stays released for the whole DMA block; a stray wait would
    // stall a DMA engine that has no wait input
    if (s_reg.busy) begin
      s_next.wait_n = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Clock enable low holds every bit, port pins included; reset
  // leaves every strobe released and the bus undriven
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg.st <= DS_IDLE;
      s_reg.wcnt <= 2'h0;
      s_reg.wait_n <= 1'b1;
      s_reg.req_n <= 1'b1;
      s_reg.dout <= DATA_RESET;
      s_reg.doe <= 1'b0;
      s_reg.pop <= 1'b0;
      s_reg.busy <= 1'b0;
      s_reg.left <= '0;
      s_reg.done <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Slave only: no address or strobe outputs exist here
  assign port.wait_n = s_reg.wait_n;
  assign port.dma_request_n = s_reg.req_n;
  assign port.data_out = s_reg.dout;
  assign port.data_oe = s_reg.doe;
  // Local handshake and count
  assign fifo_pop = s_reg.pop;
  assign dma_busy = s_reg.busy;
  assign dma_done_cnt = s_reg.done;
endmodule : hpf_dev

/* File: hpf_proc.sv */
`timescale 1ns/1ns
// Processor end: direct FIFO reads and block DMA reads.
module hpf_proc #(
  parameter int CNT_WIDTH = hpf_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  hpf_port_if.proc port,
  // One direct FIFO read per pulse
  input wire logic rd_req,
  // DMA transfer count programmed before the request
  input wire logic [CNT_WIDTH-1:0] dma_count,
  output logic [hpf_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy
);
  import hpf_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    hpf_proc_state_t st;
    logic dma;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic ack_n;
    logic [CNT_WIDTH-1:0] left;
    logic [DATA_W-1:0] data;
    logic valid;
    logic late;
    logic busy;
  } hpf_proc_regs_t;

  hpf_proc_regs_t s_reg;
  hpf_proc_regs_t s_next;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    case (s_reg.st)
      PS_IDLE: begin
        if (!port.dma_request_n && dma_count != '0) begin
          s_next.dma = 1'b1;
          s_next.left = dma_count;
          s_next.addr = DMA_PORT_ADDR;
          s_next.ack_n = 1'b0;
          s_next.st = PS_SEL;
        end else if (rd_req && !s_reg.dma) begin
          s_next.dma = 1'b0;
          s_next.addr = DIRECT_FIFO_ADDR;
          s_next.st = PS_SEL;
        end
      end
      PS_SEL: begin
        s_next.cs_n = 1'b0;
        s_next.st = PS_OE;
      end
      PS_OE: begin
        s_next.oe_n = 1'b0;
        s_next.st = PS_CAP;
      end
      PS_CAP: begin
        // DMA has no wait, so one settle cycle covers the word; a direct
        // read first sees wait low, which tolerates either strobe order
        if (!s_reg.late) begin
          if (s_reg.dma || !port.wait_n) begin
            s_next.late = 1'b1;
          end
        end else if (s_reg.dma || port.wait_n) begin
          s_next.data = port.data;
          s_next.valid = 1'b1;
          s_next.late = 1'b0;
          s_next.st = PS_DROP_OE;
        end
      end
      PS_DROP_OE: begin
        s_next.oe_n = 1'b1;
        s_next.st = PS_DROP_CS;
      end
      PS_DROP_CS: begin
        s_next.cs_n = 1'b1;
        s_next.st = s_reg.dma ? PS_DROP_ACK : PS_IDLE;
      end
      PS_DROP_ACK: begin
        s_next.ack_n = 1'b1;
        s_next.left = s_reg.left - CNT_WIDTH'(1);
        s_next.st = PS_IDLE;
      end
      default: begin
        s_next.st = PS_IDLE;
      end
    endcase
    // Further block words: re-grant without a new request
    if (s_reg.st == PS_IDLE && s_reg.dma && s_reg.left != '0) begin
      s_next.ack_n = 1'b0;
      s_next.st = PS_SEL;
    end else if (s_reg.st == PS_IDLE && s_reg.dma) begin
      s_next.dma = 1'b0;
      s_next.st = PS_IDLE;
    end
    // Registered so the busy output never glitches
    s_next.busy = (s_next.st != PS_IDLE) || s_next.dma;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg.st <= PS_IDLE;
      s_reg.dma <= 1'b0;
      s_reg.addr <= 8'h00;
      s_reg.cs_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
      s_reg.ack_n <= 1'b1;
      s_reg.left <= '0;
      s_reg.data <= DATA_RESET;
      s_reg.valid <= 1'b0;
      s_reg.late <= 1'b0;
      s_reg.busy <= 1'b0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign port.addr = s_reg.addr;
  assign port.cs_n = s_reg.cs_n;
  assign port.oe_n = s_reg.oe_n;
  assign port.dma_grant_n = s_reg.ack_n;
  assign rd_data = s_reg.data;
  assign rd_valid = s_reg.valid;
  assign busy = s_reg.busy;
endmodule : hpf_proc

/* File: hpf_port_sva.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port handshake checker
// ------------------------------------------------------------
module hpf_port_sva
  import hpf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic wait_n,
  input wire logic dma_request_n,
  input wire logic dma_grant_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Select of the fifo address outside a grant
  sequence direct_sel_s;
    $fell(cs_n) && addr == DIRECT_FIFO_ADDR && dma_grant_n;
  endsequence
  // All three strobes of a block word are low
  sequence dma_strobe_s;
    !dma_grant_n && !cs_n && !oe_n;
  endsequence
  req_hold_a: assert property (
    !dma_request_n && dma_grant_n |=> !dma_request_n)
    else $error("request dropped before grant");
  req_release_a: assert property (
    !dma_request_n && !dma_grant_n |=> dma_request_n)
    else $error("request kept after grant");
  single_req_a: assert property (
    $rose(dma_request_n) |=> dma_request_n [*8])
    else $error("request raised again inside block");
  dma_no_wait_a: assert property (!dma_grant_n |-> wait_n)
    else $error("wait low during block transfer");
  dma_word_a: assert property (dma_strobe_s |-> ##[1:8] data_oe)
    else $error("block word not driven");
  direct_wait_a: assert property (direct_sel_s |=> !wait_n)
    else $error("wait not asserted on fifo select");
  wait_end_a: assert property (
    $fell(wait_n) |-> ##[1:12] (wait_n && data_oe))
    else $error("wait released without data");
  data_stands_a: assert property (
    data_oe && !cs_n ##1 !cs_n |-> data_oe && $stable(data_out))
    else $error("data changed under select");
  slave_only_a: assert property (
    data_oe |-> !cs_n || !$past(cs_n))
    else $error("data driven without select");
endmodule : hpf_port_sva

/* File: tb_top.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench joining both port ends
// ------------------------------------------------------------
module tb_top;
  import hpf_pkg::*;
  logic clk_sys, reset_n, clk_en, fifo_valid, fifo_pop, dma_start;
  logic dma_busy, rd_req, rd_valid, busy, wait_seen;
  logic [DATA_W-1:0] fifo_data, rd_data, exp_word;
  logic [CNT_W-1:0] dma_words, dma_done_cnt, dma_count;
  logic [ADDR_W-1:0] dma_addr;
  int miscompares, samples_checked, req_falls;
  hpf_port_if hpf_port_if_i ();
  hpf_dev hpf_dev_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .port(hpf_port_if_i), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_pop(fifo_pop),
    .dma_start(dma_start), .dma_words(dma_words),
    .dma_busy(dma_busy), .dma_done_cnt(dma_done_cnt));
  hpf_proc hpf_proc_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .port(hpf_port_if_i), .rd_req(rd_req),
    .dma_count(dma_count), .rd_data(rd_data), .rd_valid(rd_valid),
    .busy(busy));
  hpf_port_sva hpf_port_sva_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(hpf_port_if_i.addr), .cs_n(hpf_port_if_i.cs_n),
    .oe_n(hpf_port_if_i.oe_n), .wait_n(hpf_port_if_i.wait_n),
    .dma_request_n(hpf_port_if_i.dma_request_n),
    .dma_grant_n(hpf_port_if_i.dma_grant_n),
    .data_out(hpf_port_if_i.data_out), .data_oe(hpf_port_if_i.data_oe));
  // ------------------------------------------------------------
  // Clock, fifo model and wire watchers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Fifo steps on pop; watchers sample settled wires
  always @(negedge clk_sys) begin
    if (fifo_pop === 1'b1) fifo_data <= fifo_data + 32'h1;
    if (hpf_port_if_i.wait_n === 1'b0) wait_seen = 1'b1;
    if (!hpf_port_if_i.dma_grant_n && !hpf_port_if_i.cs_n) begin
      dma_addr = hpf_port_if_i.addr;
    end
  end
  // Count request edges to prove one per block
  always @(negedge hpf_port_if_i.dma_request_n) begin
    if (reset_n) req_falls++;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Bounded wait for one captured word
  task wait_word;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (rd_valid === 1'b1) break;
    end
    chk("rd_valid", {31'h0, rd_valid}, 32'h1);
    chk("rd_data", rd_data, exp_word);
    exp_word++;
  endtask : wait_word
  // Let both ends go idle so a pulse request is not lost
  task settle;
    for (int i = 0; i < 20 && (busy !== 1'b0 || dma_busy !== 1'b0);
         i++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask : settle
  // Stall the fifo so wait outlasts the wait count
  task direct_read(input int stall);
    settle();
    wait_seen = 1'b0;
    fifo_valid = (stall == 0);
    rd_req = 1'b1;
    @(negedge clk_sys);
    rd_req = 1'b0;
    repeat (stall) @(negedge clk_sys);
    fifo_valid = 1'b1;
    wait_word();
    chk("wait seen", {31'h0, wait_seen}, 32'h1);
    chk("fifo pops", fifo_data, exp_word);
  endtask : direct_read
  task test_direct;
    direct_read(0);
    direct_read(8);
    $display("test direct reads done");
  endtask : test_direct
  // Clock enable low mid read must hold wait and the word back
  task test_freeze;
    settle();
    rd_req = 1'b1;
    @(negedge clk_sys);
    rd_req = 1'b0;
    repeat (2) @(negedge clk_sys);
    clk_en = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("frozen wait", {31'h0, hpf_port_if_i.wait_n}, 32'h0);
    clk_en = 1'b1;
    wait_word();
    $display("test clock enable freeze done");
  endtask : test_freeze
  // One request must carry the whole block
  task test_dma(input int n);
    settle();
    req_falls = 0;
    wait_seen = 1'b0;
    dma_addr = 8'h00;
    dma_count = 16'(n);
    dma_words = 16'(n);
    dma_start = 1'b1;
    @(negedge clk_sys);
    dma_start = 1'b0;
    for (int k = 0; k < n; k++) wait_word();
    for (int i = 0; i < 40 && dma_busy !== 1'b0; i++) @(negedge clk_sys);
    chk("dma_busy", {31'h0, dma_busy}, 32'h0);
    chk("proc busy", {31'h0, busy}, 32'h0);
    chk("done count", {16'h0, dma_done_cnt}, 32'(n));
    chk("requests", 32'(req_falls), 32'h1);
    chk("dma addr", {24'h0, dma_addr}, {24'h0, DMA_PORT_ADDR});
    chk("wait in dma", {31'h0, wait_seen}, 32'h0);
    repeat (20) @(negedge clk_sys);
    $display("test block of %0d words done", n);
  endtask : test_dma
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    miscompares = 0;
    samples_checked = 0;
    {clk_en, fifo_valid, rd_req, dma_start, reset_n} = 5'h18;
    fifo_data = 32'ha5a5_0001;
    exp_word = 32'ha5a5_0001;
    dma_words = 16'h0000;
    dma_count = 16'h0000;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    test_direct();
    test_freeze();
    test_dma(1);
    test_dma(3);
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
